/* File: src/fsdc_top.sv */
// Purpose: digital control of a fractional-N synthesizer
// Assumes: reference clock enters as a pin sampled on clk_i
// Notes:   chip enable low acts as a second, synchronous clear
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fsdc_top
    import fsdc_pkg::*;
#(
    parameter int REG_UP_CYC = FSDC_REG_UP_CYC
) (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // pins
    input  wire logic        chip_enable_i,
    input  wire logic        osc_drive_pin_i,
    output logic             osc_drive_pin_o,
    output logic             osc_drive_pin_oe_o,
    output logic             divided_ref_output_o,
    output logic             status_mux_o,
    // analog controls
    output logic             xtal_osc_run_o,
    output logic             vco_enable_o,
    output logic             output_halving_o,
    output logic [3:0]       osc_bias_field_o,
    output logic [1:0]       osc_recenter_field_o,
    output logic             comparator_clk_o,
    output logic [7:0]       fb_int_o
);

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic ce_m_reg, ce_reg, ref_m_reg, ref_reg, ref_d_reg;

    // two stages per pin before any logic looks at them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ce_m_reg  <= 1'b0;
            ce_reg    <= 1'b0;
            ref_m_reg <= 1'b0;
            ref_reg   <= 1'b0;
            ref_d_reg <= 1'b0;
        end else begin
            ce_m_reg  <= chip_enable_i;
            ce_reg    <= ce_m_reg;
            ref_m_reg <= osc_drive_pin_i;
            ref_reg   <= ref_m_reg;
            ref_d_reg <= ref_reg;
        end
    end

    logic clr;
    logic ref_rise;
    assign clr      = rst_i | ~ce_reg;
    assign ref_rise = ref_reg & ~ref_d_reg;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    fsdc_wb_req_s req;
    fsdc_ref_s    ref_reg_s;
    logic         loop_enable_bit_reg;
    logic [2:0]   status_select_field_reg;
    logic [7:0]   int_reg;
    logic [14:0]  frac_reg;
    logic [7:0]   pherr_reg;
    logic         pherr_new_reg;
    logic         regrdy_reg;
    logic         lock_reg;
    logic         wr_ok;
    logic [31:0]  ctrl_word, ref_word, ndiv_word, stat_word, wr_word;

    assign req   = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};
    // writes dropped until the regulator is up and ce is high
    assign wr_ok = req.cyc & req.stb & req.we & ~wb_ack_o & regrdy_reg;

    // byte-lane merge of write data into the addressed word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign ctrl_word = {status_select_field_reg, loop_enable_bit_reg, 28'h0};
    assign ref_word  = {5'h0, ref_reg_s.rdiv, 2'h0, ref_reg_s.recenter, ref_reg_s.bias,
                        2'h0, ref_reg_s.halve, ref_reg_s.xtal_en, ref_reg_s.outdiv, 8'h00};
    assign ndiv_word = {8'h00, int_reg, 1'b0, frac_reg};
    assign stat_word = {29'h0, ce_reg, lock_reg, regrdy_reg};

    always_comb begin
        unique case (req.adr)
            FSDC_ADDR_CTRL: wr_word = merge(ctrl_word, req.dat, req.sel);
            FSDC_ADDR_REF:  wr_word = merge(ref_word, req.dat, req.sel);
            FSDC_ADDR_NDIV: wr_word = merge(ndiv_word, req.dat, req.sel);
            default:        wr_word = merge(32'h0, req.dat, req.sel);
        endcase
    end

    // control word: loop enable and status select
    always_ff @(posedge clk_i) begin
        if (clr) begin
            loop_enable_bit_reg     <= 1'b0;
            status_select_field_reg <= FSDC_MUX_RST;
        end else if (wr_ok && req.adr == FSDC_ADDR_CTRL) begin
            loop_enable_bit_reg     <= wr_word[FSDC_LOOP_EN_BIT];
            status_select_field_reg <= wr_word[FSDC_MUX_LSB +: 3];
        end
    end

    // reference word; a zero r is read as one
    always_ff @(posedge clk_i) begin
        if (clr) begin
            ref_reg_s.outdiv   <= FSDC_OUTDIV_RST;
            ref_reg_s.xtal_en  <= 1'b1;
            ref_reg_s.halve    <= 1'b0;
            ref_reg_s.bias     <= FSDC_BIAS_RST;
            ref_reg_s.recenter <= FSDC_RECENTER_RST;
            ref_reg_s.rdiv     <= FSDC_RDIV_RST;
        end else if (wr_ok && req.adr == FSDC_ADDR_REF) begin
            ref_reg_s.outdiv   <= wr_word[FSDC_OUTDIV_LSB +: 4];
            ref_reg_s.xtal_en  <= wr_word[FSDC_XTAL_EN_BIT];
            ref_reg_s.halve    <= wr_word[FSDC_HALVE_BIT];
            ref_reg_s.bias     <= wr_word[FSDC_BIAS_LSB +: 4];
            ref_reg_s.recenter <= wr_word[FSDC_RECENTER_LSB +: 2];
            ref_reg_s.rdiv     <= (wr_word[FSDC_RDIV_LSB +: 3] == 3'h0) ? 3'h1
                                  : wr_word[FSDC_RDIV_LSB +: 3];
        end
    end

    // feedback divider word; integer below the floor is clamped
    always_ff @(posedge clk_i) begin
        if (clr) begin
            int_reg  <= FSDC_INT_MIN;
            frac_reg <= 15'h0000;
        end else if (wr_ok && req.adr == FSDC_ADDR_NDIV) begin
            int_reg  <= (wr_word[FSDC_INT_LSB +: 8] < FSDC_INT_MIN) ? FSDC_INT_MIN
                        : wr_word[FSDC_INT_LSB +: 8];
            frac_reg <= wr_word[FSDC_FRAC_LSB +: 15];
        end
    end

    // phase error sample, in ns, written over the bus by the host
    always_ff @(posedge clk_i) begin
        if (clr) begin
            pherr_reg     <= 8'hff;
            pherr_new_reg <= 1'b0;
        end else begin
            pherr_new_reg <= wr_ok && req.adr == FSDC_ADDR_PHERR;
            if (wr_ok && req.adr == FSDC_ADDR_PHERR) begin
                pherr_reg <= wr_word[7:0];
            end
        end
    end

    // wishbone answer one cycle after the strobe, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req.cyc & req.stb & ~wb_ack_o;
            unique case (req.adr)
                FSDC_ADDR_CTRL:   wb_dat_o <= ctrl_word;
                FSDC_ADDR_REF:    wb_dat_o <= ref_word;
                FSDC_ADDR_NDIV:   wb_dat_o <= ndiv_word;
                FSDC_ADDR_STATUS: wb_dat_o <= stat_word;
                FSDC_ADDR_PHERR:  wb_dat_o <= {24'h0, pherr_reg};
                default:          wb_dat_o <= 32'h0;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // regulator ready timer
    // -----------------------------------------------------------------
    logic [11:0] up_cnt_reg;

    // counts from ce rising; timing is a model of the analog ramp
    always_ff @(posedge clk_i) begin
        if (clr) begin
            up_cnt_reg <= 12'h000;
            regrdy_reg <= 1'b0;
        end else if (up_cnt_reg >= 12'(REG_UP_CYC - 1)) begin
            regrdy_reg <= 1'b1;
        end else begin
            up_cnt_reg <= up_cnt_reg + 12'h001;
        end
    end

    // -----------------------------------------------------------------
    // reference divider and comparator clock
    // -----------------------------------------------------------------
    logic [2:0] r_cnt_reg;

    // one comparator pulse per r reference edges
    always_ff @(posedge clk_i) begin
        if (clr) begin
            r_cnt_reg        <= 3'h0;
            comparator_clk_o <= 1'b0;
        end else begin
            comparator_clk_o <= 1'b0;
            if (ref_rise) begin
                if (r_cnt_reg + 3'h1 >= ref_reg_s.rdiv) begin
                    r_cnt_reg        <= 3'h0;
                    comparator_clk_o <= 1'b1;
                end else begin
                    r_cnt_reg <= r_cnt_reg + 3'h1;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // digital lock detect
    // -----------------------------------------------------------------
    logic [2:0] good_cnt_reg;

    // each phase-error sample counts as one comparison cycle
    always_ff @(posedge clk_i) begin
        if (clr) begin
            good_cnt_reg <= 3'h0;
            lock_reg     <= 1'b0;
        end else if (pherr_new_reg) begin
            if (pherr_reg >= 8'(FSDC_UNLOCK_NS)) begin
                lock_reg     <= 1'b0;
                good_cnt_reg <= 3'h0;
            end else if (pherr_reg < 8'(FSDC_LOCK_NS)) begin
                if (good_cnt_reg >= 3'(FSDC_LOCK_CNT - 1)) begin
                    lock_reg <= 1'b1;
                end else begin
                    good_cnt_reg <= good_cnt_reg + 3'h1;
                end
            end else begin
                good_cnt_reg <= 3'h0;
            end
        end
    end

    // -----------------------------------------------------------------
    // output clock divider
    // -----------------------------------------------------------------
    logic [3:0] half_reg;     // active half period, in reference edges
    logic [3:0] o_cnt_reg;
    logic       running_reg;

    // ratio 2n toggles every n edges; ratio latched at period end, or every cycle while stopped
    always_ff @(posedge clk_i) begin
        if (clr) begin
            half_reg             <= FSDC_OUTDIV_RST;
            o_cnt_reg            <= 4'h0;
            running_reg          <= 1'b1;
            divided_ref_output_o <= 1'b0;
        end else if (!running_reg) begin
            divided_ref_output_o <= 1'b0;
            half_reg             <= ref_reg_s.outdiv;
            running_reg          <= ref_reg_s.outdiv != 4'h0;
            o_cnt_reg            <= 4'h0;
        end else if (ref_rise) begin
            if (o_cnt_reg + 4'h1 >= half_reg) begin
                o_cnt_reg <= 4'h0;
                if (divided_ref_output_o) begin
                    divided_ref_output_o <= 1'b0;
                    half_reg    <= ref_reg_s.outdiv;
                    running_reg <= ref_reg_s.outdiv != 4'h0;
                end else begin
                    divided_ref_output_o <= 1'b1;
                end
            end else begin
                o_cnt_reg <= o_cnt_reg + 4'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // analog control outputs and status pin
    // -----------------------------------------------------------------
    // registered so every output comes from a flip-flop
    always_ff @(posedge clk_i) begin
        if (clr) begin
            xtal_osc_run_o       <= 1'b0;
            osc_drive_pin_o      <= 1'b0;
            osc_drive_pin_oe_o   <= 1'b0;
            vco_enable_o         <= 1'b0;
            output_halving_o     <= 1'b0;
            osc_bias_field_o     <= FSDC_BIAS_RST;
            osc_recenter_field_o <= FSDC_RECENTER_RST;
            fb_int_o             <= FSDC_INT_MIN;
        end else begin
            xtal_osc_run_o       <= ref_reg_s.xtal_en;
            // crystal drives the pin; cleared bit leaves it to a tcxo
            osc_drive_pin_o      <= ~ref_reg;
            osc_drive_pin_oe_o   <= ref_reg_s.xtal_en;
            vco_enable_o         <= loop_enable_bit_reg;
            output_halving_o     <= ref_reg_s.halve;
            osc_bias_field_o     <= ref_reg_s.bias;
            osc_recenter_field_o <= ref_reg_s.recenter;
            fb_int_o             <= int_reg;
        end
    end

    // status pin mux; low while ce is low
    always_ff @(posedge clk_i) begin
        if (clr) begin
            status_mux_o <= 1'b0;
        end else begin
            unique case (status_select_field_reg)
                FSDC_MUX_REGRDY: status_mux_o <= regrdy_reg;
                FSDC_MUX_LOCK:   status_mux_o <= lock_reg;
                FSDC_MUX_REFDIV: status_mux_o <= comparator_clk_o;
                FSDC_MUX_OUTCLK: status_mux_o <= divided_ref_output_o;
                FSDC_MUX_HIGH:   status_mux_o <= 1'b1;
                default:         status_mux_o <= 1'b0;
            endcase
        end
    end

endmodule

/* File: shared/fsdc_pkg.sv */
// Purpose: constants and carriers for the synthesizer digital control block
// Assumes: 50 MHz system clock, classic wishbone register access
// Notes:   registers sit at word-aligned byte offsets
package fsdc_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] FSDC_ADDR_CTRL   = 8'h00; // loop/status select
    localparam logic [7:0] FSDC_ADDR_REF    = 8'h04; // reference/osc
    localparam logic [7:0] FSDC_ADDR_NDIV   = 8'h08; // integer and fraction
    localparam logic [7:0] FSDC_ADDR_STATUS = 8'h0c; // read-only state
    localparam logic [7:0] FSDC_ADDR_PHERR  = 8'h10; // phase error input

    // control word fields
    localparam int FSDC_LOOP_EN_BIT  = 28;
    localparam int FSDC_MUX_LSB      = 29;
    // reference word fields
    localparam int FSDC_OUTDIV_LSB   = 8;
    localparam int FSDC_XTAL_EN_BIT  = 12;
    localparam int FSDC_HALVE_BIT    = 13;
    localparam int FSDC_BIAS_LSB     = 16;
    localparam int FSDC_RECENTER_LSB = 20;
    localparam int FSDC_RDIV_LSB     = 24;
    // divider word fields
    localparam int FSDC_FRAC_LSB     = 0;
    localparam int FSDC_INT_LSB      = 16;

    // reset values
    localparam logic [3:0]  FSDC_OUTDIV_RST = 4'h4;   // divide by 8
    localparam logic [2:0]  FSDC_RDIV_RST   = 3'h1;
    localparam logic [2:0]  FSDC_MUX_RST    = 3'h0;   // regulator ready
    localparam logic [7:0]  FSDC_INT_MIN    = 8'h1f;  // 31
    localparam logic [1:0]  FSDC_RECENTER_RST = 2'h0;
    localparam logic [3:0]  FSDC_BIAS_RST   = 4'h1;

    // status mux codes
    localparam logic [2:0] FSDC_MUX_REGRDY = 3'h0;
    localparam logic [2:0] FSDC_MUX_LOCK   = 3'h1;
    localparam logic [2:0] FSDC_MUX_REFDIV = 3'h2;
    localparam logic [2:0] FSDC_MUX_OUTCLK = 3'h3;
    localparam logic [2:0] FSDC_MUX_LOW    = 3'h4;
    localparam logic [2:0] FSDC_MUX_HIGH   = 3'h5;

    // timing
    localparam int FSDC_CLK_HZ        = 50_000_000;
    localparam int FSDC_REG_UP_US     = 50;
    localparam int FSDC_REG_UP_CYC    = FSDC_REG_UP_US * (FSDC_CLK_HZ / 1_000_000);
    localparam int FSDC_LOCK_NS       = 15;
    localparam int FSDC_UNLOCK_NS     = 25;
    localparam int FSDC_LOCK_CNT      = 5;
    localparam logic [11:0] FSDC_REG_UP_CYC_W = 12'(FSDC_REG_UP_CYC);

    // wishbone request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } fsdc_wb_req_s;

    // reference settings carrier
    typedef struct packed {
        logic [2:0] rdiv;
        logic [1:0] recenter;
        logic [3:0] bias;
        logic       halve;
        logic       xtal_en;
        logic [3:0] outdiv;
    } fsdc_ref_s;

endpackage

/* File: verification/fsdc_assertions.sv */
// Purpose: port-level checks of the synthesizer control block
// Assumes: one clock domain, rst_i synchronous active high
// Notes:   REG_UP_CYC of at least 4; bound after the module
`timescale 1ns/1ps
module fsdc_assertions
    import fsdc_pkg::*;
#(
    parameter int REG_UP_CYC = FSDC_REG_UP_CYC
) (
    // system
    input wire logic       clk_i,
    input wire logic       rst_i,
    // bus
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // pins
    input wire logic       chip_enable_i,
    input wire logic       divided_ref_output_o,
    input wire logic       status_mux_o,
    input wire logic       xtal_osc_run_o,
    input wire logic       osc_drive_pin_oe_o,
    input wire logic       vco_enable_o,
    input wire logic       comparator_clk_o,
    input wire logic [7:0] fb_int_o
);
    // slack covers the two pin flops and the registered mux
    localparam int RDY_MAX = REG_UP_CYC + 8;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ce_gone; !chip_enable_i [*4]; endsequence
    sequence s_ready; !status_mux_o [*4] ##[1:RDY_MAX] status_mux_o; endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_ack_next; s_req |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ce_clear;
        s_ce_gone |=> !xtal_osc_run_o && !osc_drive_pin_oe_o && !vco_enable_o;
    endproperty
    property p_ce_int; s_ce_gone |=> fb_int_o == FSDC_INT_MIN; endproperty
    property p_int_floor; fb_int_o >= FSDC_INT_MIN; endproperty
    property p_cmp_pulse; comparator_clk_o |=> !comparator_clk_o; endproperty
    // a ratio change must never leave a sliver of a half period
    property p_div_clean;
        $changed(divided_ref_output_o) |=> $stable(divided_ref_output_o) [*2];
    endproperty
    property p_ready; $fell(rst_i) && chip_enable_i |-> s_ready; endproperty
    a_ack_next:  assert property (p_ack_next)  else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ce_clear:  assert property (p_ce_clear)  else $error("oscillator on without ce");
    a_ce_int:    assert property (p_ce_int)    else $error("integer not cleared");
    a_int_floor: assert property (p_int_floor) else $error("integer below floor");
    a_cmp_pulse: assert property (p_cmp_pulse) else $error("comparator pulse too long");
    a_div_clean: assert property (p_div_clean) else $error("divided output glitch");
    a_ready:     assert property (p_ready)     else $error("ready not shown on mux");
endmodule
bind fsdc_top fsdc_assertions #(.REG_UP_CYC(REG_UP_CYC)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .chip_enable_i(chip_enable_i),
    .divided_ref_output_o(divided_ref_output_o), .status_mux_o(status_mux_o),
    .xtal_osc_run_o(xtal_osc_run_o), .osc_drive_pin_oe_o(osc_drive_pin_oe_o),
    .vco_enable_o(vco_enable_o), .comparator_clk_o(comparator_clk_o),
    .fb_int_o(fb_int_o));

/* File: verification/fsdc_host_model.sv */
// Purpose: host and reference source beside the synthesizer control
// Assumes: reference runs free, crystal or external CMOS alike
// Notes:   prog_ok_o gates the bench's programming
`timescale 1ns/1ps
module fsdc_host_model #(
    parameter int REF_HALF = 3
) (
    // system
    input  wire logic clk_i,
    input  wire logic power_req_i,
    input  wire logic status_i,
    // toward the device
    output logic      chip_enable_o,
    output logic      ref_clk_o,
    output logic      prog_ok_o
);
    int half_cnt = 0;
    initial begin
        chip_enable_o = 1'b1;
        ref_clk_o = 1'b0;
        prog_ok_o = 1'b0;
    end
    // reference never stops, so no idle level to model
    always @(posedge clk_i) begin
        half_cnt <= (half_cnt == REF_HALF - 1) ? 0 : half_cnt + 1;
        if (half_cnt == REF_HALF - 1) begin
            ref_clk_o <= ~ref_clk_o;
        end
        chip_enable_o <= power_req_i;
    end
    // programming only once ce is up and ready has been seen
    always @(posedge clk_i) begin
        if (!chip_enable_o) begin
            prog_ok_o <= 1'b0;
        end else if (status_i) begin
            prog_ok_o <= 1'b1;
        end
    end
endmodule

/* File: verification/fsdc_tb.sv */
// Purpose: self-checking bench for the synthesizer control block
// Assumes: reference half period of RH clocks from the host model
// Notes:   short regulator wait through REG_UP_CYC
`timescale 1ns/1ps
module fsdc_tb;
    import fsdc_pkg::*;
    localparam int RH = 3;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pwr = 1'b1;
    fsdc_wb_req_s req = '0;
    logic [31:0] wb_dat_o, rd, seed;
    logic wb_ack_o, ce, refc, pok, osc_o, osc_oe, div_o, mux_o, xrun, vco, halve, cmp;
    logic [3:0] bias;
    logic [1:0] rec;
    logic [7:0] fbi, iv;
    int miscompares = 0;
    int n_checks = 0;
    int c, k, i, n;
    always #10 clk_i = ~clk_i;
    fsdc_host_model #(.REF_HALF(RH)) u_host (.clk_i(clk_i), .power_req_i(pwr),
        .status_i(mux_o), .chip_enable_o(ce), .ref_clk_o(refc), .prog_ok_o(pok));
    // crystal and external source both show the reference on the pin
    fsdc_top #(.REG_UP_CYC(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
        .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .chip_enable_i(ce), .osc_drive_pin_i(refc), .osc_drive_pin_o(osc_o),
        .osc_drive_pin_oe_o(osc_oe), .divided_ref_output_o(div_o), .status_mux_o(mux_o),
        .xtal_osc_run_o(xrun), .vco_enable_o(vco), .output_halving_o(halve),
        .osc_bias_field_o(bias), .osc_recenter_field_o(rec), .comparator_clk_o(cmp),
        .fb_int_o(fbi));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_int(input logic [7:0] v);
        return (v < FSDC_INT_MIN) ? FSDC_INT_MIN : v;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // classic cycle: held until ack is sampled, then dropped
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        k = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) miscompares++;
        rd = wb_dat_o;
        req <= '0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wait_ok;
        for (k = 0; k < 300 && pok !== 1'b1; k++) @(posedge clk_i);
        if (pok !== 1'b1) miscompares++;
    endtask
    task automatic half_len;
        k = 0;
        c = 0;
        while (div_o !== 1'b0 && k < 500) begin @(posedge clk_i); k++; end
        while (div_o !== 1'b1 && k < 500) begin @(posedge clk_i); k++; end
        while (div_o === 1'b1 && k < 500) begin @(posedge clk_i); c++; k++; end
    endtask
    task automatic pulse_gap;
        for (k = 0; k < 200 && cmp !== 1'b1; k++) @(posedge clk_i);
        @(posedge clk_i);
        for (c = 1; c < 200 && cmp !== 1'b1; c++) @(posedge clk_i);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h08d2;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_ok();
        wb(1'b0, FSDC_ADDR_STATUS, 32'h0); chk(rd, 32'h5);
        wb(1'b0, FSDC_ADDR_REF, 32'h0); chk(rd, 32'h0101_1400);
        wb(1'b0, FSDC_ADDR_NDIV, 32'h0); chk(rd, 32'h001f_0000);
        chk(32'(xrun), 32'h1);
        // crystal drive follows the reference: 20 changes in 60 cycles
        n = 0;
        c = int'(osc_o);
        repeat (60) begin
            @(posedge clk_i);
            if (osc_o !== c[0]) n++;
            c = int'(osc_o);
        end
        chk(32'(n), 32'd20);
        wb(1'b1, FSDC_ADDR_STATUS, '1); wb(1'b0, 8'h14, 32'h0); chk(rd, 32'h0);
        half_len(); half_len(); chk(32'(c), 32'(8 * RH));
        $display("reset values done");
        for (i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            n = (i == 0) ? 1 : (i == 1) ? 15 : 1 + int'(seed[7:0]) % 15;
            wb(1'b1, FSDC_ADDR_REF, 32'h0101_1000 | 32'(n << 8));
            half_len(); half_len(); chk(32'(c), 32'(2 * n * RH));
        end
        wb(1'b1, FSDC_ADDR_REF, 32'h0101_1000);
        repeat (200) @(posedge clk_i);
        n = 0;
        c = int'(div_o);
        repeat (200) begin @(posedge clk_i); if (div_o !== c[0]) n++; end
        chk(32'(n), 32'h0);
        chk(32'(c), 32'h0);
        for (i = 0; i < 8; i++) begin
            wb(1'b1, FSDC_ADDR_REF, 32'h0001_1400 | 32'(i << 24));
            pulse_gap(); pulse_gap(); chk(32'(c), 32'(((i == 0) ? 1 : i) * 2 * RH));
        end
        $display("dividers done");
        for (i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            // bias code drawn from the seed, kept to codes 1 to 3
            wb(1'b1, FSDC_ADDR_REF, {8'h01, 2'b0, seed[2:1], 2'b0, 2'(seed[4:3] % 3 + 1),
                2'b0, seed[0], seed[5], 12'h400});
            chk(32'(halve), 32'(seed[0]));
            chk(32'(rec), 32'(seed[2:1]));
            chk(32'(bias), 32'(seed[4:3] % 3 + 1));
            chk(32'({xrun, osc_oe}), {30'h0, seed[5], seed[5]});
            iv = (i == 0) ? 8'h00 : (i == 1) ? 8'h1e : (i == 2) ? 8'h1f : seed[15:8];
            wb(1'b1, FSDC_ADDR_NDIV, {8'h0, iv, 1'b0, seed[30:16]});
            chk(32'(fbi), 32'(exp_int(iv)));
            wb(1'b0, FSDC_ADDR_NDIV, 32'h0); chk(rd, {8'h0, exp_int(iv), 1'b0, seed[30:16]});
        end
        for (i = 0; i < 8; i++) begin
            wb(1'b1, FSDC_ADDR_CTRL, {3'(i), 1'b1, 28'h0});
            chk(32'(vco), 32'h1);
            if (i != 2 && i != 3) begin
                chk(32'(mux_o), 32'(i == 0 || i == 5));
            end else begin
                // clock sources: count changes over two output periods
                n = 0;
                c = int'(mux_o);
                repeat (96) begin
                    @(posedge clk_i);
                    if (mux_o !== c[0]) n++;
                    c = int'(mux_o);
                end
                chk(32'(n), (i == 2) ? 32'd32 : 32'd4);
            end
        end
        wb(1'b1, FSDC_ADDR_CTRL, {3'h1, 29'h0}); chk(32'(vco), 32'h0);
        for (i = 0; i < 11; i++) begin
            seed = lfsr(seed);
            wb(1'b1, FSDC_ADDR_PHERR, (i == 4) ? 32'd20 : 32'(seed[7:0] % 15));
            chk(32'(mux_o), 32'(i >= 9));
        end
        wb(1'b1, FSDC_ADDR_PHERR, 32'd24); chk(32'(mux_o), 32'h1);
        wb(1'b1, FSDC_ADDR_PHERR, 32'd25); chk(32'(mux_o), 32'h0);
        $display("settings and lock done");
        pwr <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk(32'({xrun, vco}), 32'h0);
        pwr <= 1'b1;
        repeat (5) @(posedge clk_i);
        wb(1'b1, FSDC_ADDR_NDIV, 32'h0064_0000);
        wait_ok();
        chk(32'(fbi), 32'h1f);
        wb(1'b0, FSDC_ADDR_REF, 32'h0); chk(rd, 32'h0101_1400);
        chk(32'(mux_o), 32'h1);
        $display("chip enable done");
        report_and_stop();
    end
endmodule
